/* File: dv/fperr_pic_model.sv */
// Model of the interrupt controller that watches the error pin.
// Assumes an active-low pin; the bench sets the answer latency.
module fperr_pic_model (
  // Clock and latency
  input wire logic i_clk,
  input wire logic [3:0] i_delay,
  // Error pin in, request out
  input wire logic i_fp_error_out_n,
  output logic o_irq
);
  logic [3:0] cnt_r = 4'h0;
  // Line 13 counts toward vector 75H; an unknown pin counts as released
  always @(posedge i_clk) begin
    if (i_fp_error_out_n !== 1'b0) cnt_r <= 4'h0;
    else if (cnt_r != i_delay) cnt_r <= cnt_r + 4'h1;
  end
  // Request stands once the latency has run, drops with the pin
  assign o_irq = (i_fp_error_out_n === 1'b0) && (cnt_r == i_delay);
endmodule

/* File: dv/fperr_report_checker.sv */
// Checker for the error pin reporting block, bound to every fperr_report.
// Assumes one core clock and an active-low synchronous reset.
module fperr_report_checker
  import fperr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Block inputs
  input wire logic [31:0] i_processor_control_reg_zero,
  input wire logic i_exc_valid,
  input wire logic [5:0] i_exc_flags,
  input wire logic [5:0] i_exc_masks,
  input wire logic i_issue_valid,
  input wire fperr_cls_t i_issue_cls,
  input wire logic i_ignore_fp_error_in_n,
  input wire logic i_maskable_interrupt_request,
  // Block outputs
  input wire logic o_fp_error_out_n,
  input wire logic [5:0] o_exc_flags,
  input wire logic o_error_summary_flag,
  input wire logic o_issue_stall,
  input wire logic o_fp_error_vector,
  input wire logic o_single_lp_only
);
  // Issue slot decode; clearing classes end the error report
  wire ne = i_processor_control_reg_zero[FPERR_NE_BIT];
  wire waiting = i_issue_valid && i_issue_cls inside {FPERR_CLS_WAITING_FP, FPERR_CLS_WAIT, FPERR_CLS_SIMD};
  wire clears = i_issue_valid && i_issue_cls inside {FPERR_CLS_NOWAIT_INIT, FPERR_CLS_NOWAIT_CLEX, FPERR_CLS_NOWAIT_SAVE};
  wire nowait = clears || (i_issue_valid && i_issue_cls == FPERR_CLS_NOWAIT_STORE);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_summary_set: assert property (i_exc_valid && ne && |(i_exc_flags & ~i_exc_masks) |=> o_error_summary_flag)
    else $error("summary flag not set");
  a_summary_or: assert property (o_error_summary_flag == |o_exc_flags) else $error("summary not OR of flags");
  a_err_cause: assert property (!o_fp_error_out_n |-> o_error_summary_flag) else $error("error pin without flag");
  a_pin_hold: assert property (i_ignore_fp_error_in_n [*5] ##0 (!ne && !o_fp_error_out_n && !clears)
    |=> !o_fp_error_out_n) else $error("error pin released early");
  a_native_trap: assert property (ne && o_error_summary_flag && waiting |=> o_fp_error_vector) else $error("no trap");
  a_pin_no_trap: assert property (!ne |=> !o_fp_error_vector) else $error("trap in pin mode");
  a_nowait_quiet: assert property (nowait |=> !o_issue_stall && !o_fp_error_vector) else $error("nowait held");
  a_stall_wait: assert property ((!i_maskable_interrupt_request && i_ignore_fp_error_in_n) [*5] ##0
    (!ne && o_error_summary_flag && waiting) |=> o_issue_stall) else $error("no stall at waiting op");
  a_ignore_quiet: assert property ((!i_ignore_fp_error_in_n) [*5] |=> !o_issue_stall && o_fp_error_out_n)
    else $error("error reported while ignored");
  a_single_lp: assert property ($past(i_resetn) && $stable(i_processor_control_reg_zero) |-> o_single_lp_only == !ne)
    else $error("single processor flag wrong");
endmodule
bind fperr_report fperr_report_checker u_fperr_report_checker (.*);

/* File: dv/fperr_report_tb_top.sv */
// Bench for the error pin reporting block with a controller model.
// Assumes inputs change on the falling edge; outputs read there too.
module fperr_report_tb_top
  import fperr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, ev = 1'b0, iv = 1'b0, ign_n = 1'b1, irq, err_n, summ, stall, vec, slp;
  logic [31:0] cr0 = 32'h0, ip = 32'h0, fip;
  logic [5:0] fl = 6'h00, mk = 6'h00, oflg;
  logic [7:0] vnum;
  logic [3:0] dly = 4'h9;
  fperr_cls_t cls = FPERR_CLS_NONE;
  int miscompares = 0, compares = 0;
  // Types 4 and 5 defer the pin so both timings are exercised
  fperr_report #(.IMMEDIATE_MASK(6'h0F)) u_fperr_report (.i_core_clk(clk), .i_resetn(rstn),
    .i_processor_control_reg_zero(cr0),
    .i_exc_valid(ev), .i_exc_flags(fl), .i_exc_masks(mk), .i_exc_ip(ip), .i_issue_valid(iv), .i_issue_cls(cls),
    .i_ignore_fp_error_in_n(ign_n), .i_maskable_interrupt_request(irq), .o_fp_error_out_n(err_n),
    .o_exc_flags(oflg), .o_error_summary_flag(summ), .o_fault_ip(fip), .o_issue_stall(stall),
    .o_fp_error_vector(vec), .o_vector_num(vnum), .o_single_lp_only(slp));
  fperr_pic_model u_fperr_pic_model (.i_clk(clk), .i_delay(dly), .i_fp_error_out_n(err_n), .o_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle exception report, outputs settled on return
  task automatic exc(input logic [5:0] f, input logic [5:0] m);
    ev = 1'b1;
    fl = f;
    mk = m;
    ip = ip + 32'h10;
    @(negedge clk);
    ev = 1'b0;
  endtask
  // Instruction placed at issue; it stays there until the next call
  task automatic iss(input fperr_cls_t c);
    iv = 1'b1;
    cls = c;
    @(negedge clk);
  endtask
  // Pin mode: flag, pin, stall until the slow controller answers, clear
  task automatic t_pin();
    int n;
    exc(6'h04, 6'h00);
    chk(oflg, 6'h04);
    chk(summ, 1'b1);
    chk(err_n, 1'b0);
    chk(fip, ip);
    chk(slp, 1'b1);
    exc(6'h02, 6'h02);
    chk(oflg, 6'h04);
    iss(FPERR_CLS_NOWAIT_STORE);
    chk(stall, 1'b0);
    iss(FPERR_CLS_WAIT);
    chk(stall, 1'b1);
    n = 0;
    while (stall === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(stall, 1'b0);
    iss(FPERR_CLS_NOWAIT_CLEX);
    chk(oflg, 6'h00);
    chk(err_n, 1'b1);
  endtask
  // Deferred type: pin waits for a waiting op, then stall until answered
  task automatic t_def();
    int n;
    iss(FPERR_CLS_NONE);
    repeat (4) @(negedge clk);
    exc(6'h10, 6'h00);
    chk(oflg, 6'h10);
    chk(err_n, 1'b1);
    chk(fip, ip);
    iss(FPERR_CLS_NOWAIT_STORE);
    chk(err_n, 1'b1);
    iss(FPERR_CLS_WAITING_FP);
    chk(err_n, 1'b0);
    chk(stall, 1'b1);
    n = 0;
    while (stall === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(stall, 1'b0);
    iss(FPERR_CLS_NOWAIT_SAVE);
    chk(oflg, 6'h00);
    chk(err_n, 1'b1);
  endtask
  // Ignore asserted: a new unmasked fault leaves no trace
  task automatic t_ign();
    ign_n = 1'b0;
    iss(FPERR_CLS_NONE);
    repeat (4) @(negedge clk);
    exc(6'h01, 6'h00);
    chk(oflg, 6'h00);
    chk(err_n, 1'b1);
    ign_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // Native mode: trap at a packed-integer op, pin left alone
  task automatic t_nat();
    cr0 = 32'h20;
    iss(FPERR_CLS_NONE);
    chk(slp, 1'b0);
    exc(6'h08, 6'h00);
    chk(err_n, 1'b1);
    iss(FPERR_CLS_SIMD);
    chk(vec, 1'b1);
    chk(vnum, 8'h10);
    iss(FPERR_CLS_NOWAIT_INIT);
    chk(oflg, 6'h00);
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_pin();
    t_def();
    t_ign();
    t_nat();
    stop_test();
  end
  // Run needs under 100 cycles; a hang ends here instead
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule

/* File: rtl/fperr_pkg.sv */
// Package for the floating-point error pin reporting block.
// Assumes a single core clock domain; shared by the block and its bench.
package fperr_pkg;

  // ----------------------------------------------------------------
  // Exception flag layout
  // ----------------------------------------------------------------
  localparam int FPERR_NUM_EXC = 6;
  localparam logic [5:0] FPERR_EXC_CLR = 6'h00;
  // Position of the mode select bit in processor control register zero
  localparam int FPERR_NE_BIT = 5;
  localparam int FPERR_CR0_W = 32;
  // Internal vector used in native mode
  localparam logic [7:0] FPERR_VECTOR = 8'h10;
  localparam int FPERR_IP_W = 32;
  localparam logic [31:0] FPERR_IP_RST = 32'h00000000;
  // Synchroniser reset levels: ignore pin released, no request
  localparam logic [2:0] FPERR_SYNC_HI = 3'h7;
  localparam logic [2:0] FPERR_SYNC_LO = 3'h0;

  // Instruction class presented at the issue point
  typedef enum logic [2:0] {
    FPERR_CLS_NONE,
    FPERR_CLS_WAITING_FP,
    FPERR_CLS_WAIT,
    FPERR_CLS_SIMD,
    FPERR_CLS_NOWAIT_INIT,
    FPERR_CLS_NOWAIT_CLEX,
    FPERR_CLS_NOWAIT_STORE,
    FPERR_CLS_NOWAIT_SAVE
  } fperr_cls_t;

  // Reporting state
  typedef enum logic [1:0] {
    FPERR_ST_IDLE,
    FPERR_ST_PENDING,
    FPERR_ST_SIGNALLED
  } fperr_state_t;

endpackage

/* File: rtl/fperr_report.sv */
// Floating-point error pin reporting: flags, error pin, stall and vector.
// Assumes the execution unit presents exceptions and the next instruction's
// class on the core clock; the ignore-error pin is asynchronous.
module fperr_report
  import fperr_pkg::*;
#(
  parameter int NUM_EXC = FPERR_NUM_EXC,
  parameter int IP_W = FPERR_IP_W,
  // Exception types whose error pin assertion is immediate; others defer
  parameter logic [NUM_EXC-1:0] IMMEDIATE_MASK = 6'h3F
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Processor control register zero
  input wire logic [FPERR_CR0_W-1:0] i_processor_control_reg_zero,
  // Exception report from the execution unit
  input wire logic i_exc_valid,
  input wire logic [NUM_EXC-1:0] i_exc_flags,
  input wire logic [NUM_EXC-1:0] i_exc_masks,
  input wire logic [IP_W-1:0] i_exc_ip,
  // Next instruction at the issue point
  input wire logic i_issue_valid,
  input wire fperr_cls_t i_issue_cls,
  // External pins
  input wire logic i_ignore_fp_error_in_n,
  input wire logic i_maskable_interrupt_request,
  // Pin outputs
  output logic o_fp_error_out_n,
  // Status word flags and saved state
  output logic [NUM_EXC-1:0] o_exc_flags,
  output logic o_error_summary_flag,
  output logic [IP_W-1:0] o_fault_ip,
  // Issue control
  output logic o_issue_stall,
  output logic o_fp_error_vector,
  output logic [7:0] o_vector_num,
  output logic o_single_lp_only
);

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ign_sync_r;
  logic ign_r;
  logic [2:0] maskable_interrupt_request_sync_r;
  logic maskable_interrupt_request_r;
  logic ign_agree;
  logic maskable_interrupt_request_agree;

  // Stages two and three agree: the level is settled, not mid-change;
  // a pin pulse shorter than two clocks may go unseen
  assign ign_agree = (ign_sync_r[2] == ign_sync_r[1]);
  assign maskable_interrupt_request_agree = (maskable_interrupt_request_sync_r[2] == maskable_interrupt_request_sync_r[1]);

  // Three stages, reset to the idle levels so no false change follows
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ign_sync_r <= FPERR_SYNC_HI;
      maskable_interrupt_request_sync_r <= FPERR_SYNC_LO;
      ign_r <= 1'b0;
      maskable_interrupt_request_r <= 1'b0;
    end else begin
      ign_sync_r <= {ign_sync_r[1:0], i_ignore_fp_error_in_n};
      maskable_interrupt_request_sync_r <= {maskable_interrupt_request_sync_r[1:0], i_maskable_interrupt_request};
      if (ign_agree) begin
        ign_r <= ~ign_sync_r[2];
      end
      if (maskable_interrupt_request_agree) begin
        maskable_interrupt_request_r <= maskable_interrupt_request_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic pin_mode;
  logic [NUM_EXC-1:0] unmasked_hit;
  logic new_exc;
  logic new_imm;
  logic waiting_cls;
  logic clear_cls;
  logic pending;
  logic stall_nxt;
  logic vector_nxt;
  logic err_nxt;
  logic ign_drops;
  logic trap_point;

  // Mode select bit clear picks pin reporting
  assign pin_mode = ~i_processor_control_reg_zero[FPERR_NE_BIT];
  // Ignore pin drops new errors only in pin mode; native mode always records
  assign ign_drops = pin_mode && ign_r;
  assign unmasked_hit = (i_exc_valid && !ign_drops) ?
                        (i_exc_flags & ~i_exc_masks) : FPERR_EXC_CLR;
  assign new_exc = |unmasked_hit;
  // Error pin timing is chosen per exception type by IMMEDIATE_MASK:
  //   bit set: pin falls the cycle after the report
  //   bit clear: pin waits for the next waiting instruction
  // The instruction kind never changes the choice in this block.
  // The default makes every type immediate; a core that defers some
  // types clears their bits where it places this block.
  // Pin mode suits one active logical processor only; it is legacy,
  // so parts with several logical processors should run native mode.
  assign new_imm = |(unmasked_hit & IMMEDIATE_MASK);
  // Waiting classes check pending exceptions; non-waiting ones never do
  assign waiting_cls = i_issue_valid && (i_issue_cls == FPERR_CLS_WAITING_FP ||
                       i_issue_cls == FPERR_CLS_WAIT || i_issue_cls == FPERR_CLS_SIMD);
  assign clear_cls = i_issue_valid && (i_issue_cls == FPERR_CLS_NOWAIT_INIT ||
                     i_issue_cls == FPERR_CLS_NOWAIT_CLEX || i_issue_cls == FPERR_CLS_NOWAIT_SAVE);
  assign pending = o_error_summary_flag;

  // ----------------------------------------------------------------
  // Status flags and faulting pointer
  // ----------------------------------------------------------------
  logic [NUM_EXC-1:0] flags_nxt;

  // A new exception in the clearing cycle wins over the clear
  assign flags_nxt = (clear_cls ? FPERR_EXC_CLR : o_exc_flags) | unmasked_hit;

  // Flags are sticky; only the clearing classes drop them
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_exc_flags <= FPERR_EXC_CLR;
      o_error_summary_flag <= 1'b0;
      o_fault_ip <= FPERR_IP_RST;
    end else begin
      o_exc_flags <= flags_nxt;
      o_error_summary_flag <= |flags_nxt;
      // Newest unmasked fault; the handler restarts from it
      if (new_exc) begin
        o_fault_ip <= i_exc_ip;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reporting state machine
  // ----------------------------------------------------------------
  fperr_state_t state_r;
  fperr_state_t state_nxt;

  // Pending: error recorded, pin not yet driven (deferred type)
  // Signalled: pin driven, waiting for software to clear the flags
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FPERR_ST_IDLE: begin
        if (new_exc && pin_mode) begin
          state_nxt = new_imm ? FPERR_ST_SIGNALLED : FPERR_ST_PENDING;
        end else if (pin_mode && trap_point && !ign_r) begin
          // Flags left from native mode: drive the pin in the cycle the stall begins
          state_nxt = FPERR_ST_SIGNALLED;
        end
      end
      FPERR_ST_PENDING: begin
        // A clear with no new error abandons the deferred report
        if (clear_cls && !new_exc) begin
          state_nxt = FPERR_ST_IDLE;
        end else if (new_imm || (waiting_cls && !ign_r)) begin
          state_nxt = FPERR_ST_SIGNALLED;
        end
      end
      FPERR_ST_SIGNALLED: begin
        if (clear_cls && !new_exc) begin
          state_nxt = FPERR_ST_IDLE;
        end
      end
      default: state_nxt = FPERR_ST_IDLE;
    endcase
    // Native mode never drives the pin; drop stale state once flags are gone
    if (!pin_mode && state_nxt != FPERR_ST_IDLE && !pending && !new_exc) begin
      state_nxt = FPERR_ST_IDLE;
    end
  end

  // Pin mode freezes the core until the interrupt arrives; native mode
  // instead traps through the internal vector at the same point
  // A waiting instruction meets a pending error: the sync point
  assign trap_point = pending && waiting_cls;
  // Both land one cycle after the slot is seen, so the core must hold
  // the instruction at issue until they have settled
  assign stall_nxt = pin_mode && trap_point && !maskable_interrupt_request_r && !ign_r;
  assign vector_nxt = !pin_mode && trap_point;
  // Ignore pin holds the error pin off while a handler runs
  assign err_nxt = pin_mode && (state_nxt == FPERR_ST_SIGNALLED) && !ign_r;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Every pin and status output leaves a flop; the error pin idles high
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_r <= FPERR_ST_IDLE;
      o_fp_error_out_n <= 1'b1;
      o_issue_stall <= 1'b0;
      o_fp_error_vector <= 1'b0;
      o_vector_num <= FPERR_VECTOR;
      o_single_lp_only <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_fp_error_out_n <= ~err_nxt;
      o_issue_stall <= stall_nxt;
      o_fp_error_vector <= vector_nxt;
      o_vector_num <= FPERR_VECTOR;
      o_single_lp_only <= pin_mode;
    end
  end

endmodule
